// ===== src/lcd_seg_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - with show_ram_enable at 0 (reset) the segments carry blank data, at 1 the ram contents.
// - source select 0 runs the scan from the watch clock undivided, /2 or /4 by the low bits.
// - source select 1 runs the scan from the system clock divided by 2 up to 256 by three bits.
// - in low-power modes a system-clock source drives segments and commons low; frame_pol holds its last level.
// - one-third duty scans three commons instead of four, giving 4/3 the frame rate.
// - each ram byte holds two segments, low nibble even, high nibble odd, bit k is common k+1.
// - software fills the ram with byte or word writes and display starts on enable alone.
module lcd_seg_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic [3:0]  byteenable,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        watch_clk,
  input  wire logic        sub_clk_mode,
  output logic      [31:0] segment_line,
  output logic      [3:0]  com_line,
  output logic             frame_pol
);
  // ==========================================================
  // state
  typedef struct packed {
    logic                ack;
    logic [31:0]         rdata;
    logic [5:0]          ctrl;
    logic [15:0][7:0]    ram;
    logic [15:0][7:0]    shadow;
    logic [1:0]          wsync;
    logic                wprev;
    logic [1:0]          wcnt;
    logic [7:0]          pre;
    logic [4:0]          phase;
    logic [1:0]          com;
    logic                pol;
    logic                polv;
    logic                running;
    logic [31:0]         seg;
    logic [3:0]          comv;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // ==========================================================
  // field guide for the state record
  // ack     - high in the one cycle where waitrequest is low
  // rdata   - read data, zero outside the answer cycle
  // ctrl    - display enable, duty and frame clock select bits
  // ram     - software image of the display, sixteen bytes
  // shadow  - copy the scan reads, refreshed only at frame end
  // wsync   - two-flop synchroniser for the watch clock pin
  // wprev   - last synchronised watch level, for edge detect
  // wcnt    - watch edge divider for the /2 and /4 selections
  // pre     - system clock prescaler, /2 up to /256
  // phase   - ticks spent on the current common
  // com     - index of the common being scanned
  // pol     - polarity of the half frame being scanned
  // polv    - polarity as shown at the pins, in step with comv
  // running - status copy: scan clock present
  // seg     - registered segment pattern at the pins
  // comv    - registered one-hot common at the pins
  //
  // hazards kept in mind:
  // - the watch clock is asynchronous, so only the second flop
  //   and the edge detector behind it feed any logic
  // - the segment pattern is taken from the shadow copy, so a
  //   write in mid-frame never tears the pattern being driven
  // - the shadow loads only after both polarities were shown,
  //   which keeps the panel dc-free at the cost of up to one
  //   frame of latency for a new pattern

  logic       req;
  logic       stopped;
  logic       wedge;
  logic       tick;
  logic [7:0] pre_lim;
  logic [1:0] wlim;
  logic [1:0] com_last;
  int         byte_i;

  assign req         = read | write;
  assign waitrequest = req & ~st_r.ack;   // one wait cycle, answer on the second edge
  assign readdata    = st_r.rdata;
  assign segment_line = st_r.seg;
  assign com_line    = st_r.comv;
  assign frame_pol   = st_r.polv;   // aligned with com_line, not with the index

  // ==========================================================
  // next-state logic
  always_comb begin
    st_nxt = st_r;
    byte_i = 0;
    // bus slave: answer one cycle after the request is seen
    st_nxt.ack   = req & ~st_r.ack;
    st_nxt.rdata = 32'h0;   // zero outside the answer cycle, unmapped reads too
    // reads decode while waitrequest is high; data stands in the answer cycle
    if (read && !st_r.ack) begin
      if (address <= lcd_seg_pkg::RAM_W3_OFS && address[1:0] == 2'b00) begin
        for (int b = 0; b < 4; b++) begin
          byte_i = int'(address[3:2]) * 4 + b;
          st_nxt.rdata[b*8 +: 8] = st_r.ram[byte_i];
        end
      end else if (address == lcd_seg_pkg::CTRL_OFS) begin
        st_nxt.rdata = {26'h0, st_r.ctrl};
      end else if (address == lcd_seg_pkg::STAT_OFS) begin
        st_nxt.rdata = {27'h0, st_r.running, st_r.pol, st_r.com, 1'b0};
      end
    end
    // writes land only at the edge where waitrequest is seen low,
    // so a master that gives up early never leaves a half write
    if (write && st_r.ack) begin
      if (address <= lcd_seg_pkg::RAM_W3_OFS && address[1:0] == 2'b00) begin
        for (int b = 0; b < 4; b++) begin
          byte_i = int'(address[3:2]) * 4 + b;
          if (byteenable[b]) begin
            st_nxt.ram[byte_i] = writedata[b*8 +: 8];
          end
        end
      end else if (address == lcd_seg_pkg::CTRL_OFS && byteenable[0]) begin
        st_nxt.ctrl = writedata[5:0];
      end
    end

    // watch clock comes from a pin: two flops before any use
    st_nxt.wsync = {st_r.wsync[0], watch_clk};
    st_nxt.wprev = st_r.wsync[1];
    wedge = st_r.wsync[1] & ~st_r.wprev;

    // system clock halted in low-power modes
    stopped = st_r.ctrl[lcd_seg_pkg::SRC_BIT] & sub_clk_mode;

    // tick generation for the scan
    tick = 1'b0;
    wlim = st_r.ctrl[lcd_seg_pkg::DIV_MID] ? 2'd3 :
           (st_r.ctrl[lcd_seg_pkg::DIV_LO] ? 2'd1 : 2'd0);
    pre_lim = 8'((9'd2 << st_r.ctrl[lcd_seg_pkg::DIV_HI:lcd_seg_pkg::DIV_LO]) - 9'd1);
    if (st_r.ctrl[lcd_seg_pkg::SRC_BIT]) begin
      st_nxt.wcnt = 2'd0;
      if (stopped) begin
        st_nxt.pre = 8'h00;
      end else if (st_r.pre >= pre_lim) begin
        st_nxt.pre = 8'h00;
        tick = 1'b1;
      end else begin
        st_nxt.pre = st_r.pre + 8'd1;
      end
    end else begin
      st_nxt.pre = 8'h00;
      if (wedge) begin
        if (st_r.wcnt >= wlim) begin
          st_nxt.wcnt = 2'd0;
          tick = 1'b1;
        end else begin
          st_nxt.wcnt = st_r.wcnt + 2'd1;
        end
      end
    end

    // common scan: each common twice per frame, once per polarity
    com_last = st_r.ctrl[lcd_seg_pkg::DUTY_BIT] ? 2'd2 : 2'd3;
    st_nxt.running = ~stopped;
    if (tick) begin
      if (st_r.phase == 5'(lcd_seg_pkg::PHASE_TICKS - 1)) begin
        st_nxt.phase = 5'd0;
        if (st_r.com >= com_last) begin
          st_nxt.com = 2'd0;
          st_nxt.pol = ~st_r.pol;
          if (st_r.pol) begin
            st_nxt.shadow = st_r.ram;
          end
        end else begin
          st_nxt.com = st_r.com + 2'd1;
        end
      end else begin
        st_nxt.phase = st_r.phase + 5'd1;
      end
    end

    // segment and common drive from the shadow copy only
    // polarity follows the pin pipeline so it flips together with common 1
    st_nxt.polv = st_r.pol;
    st_nxt.comv = 4'h0;
    st_nxt.seg  = 32'h0;
    if (!stopped) begin
      st_nxt.comv = 4'h1 << st_r.com;
      for (int s = 0; s < lcd_seg_pkg::SEG_COUNT; s++) begin
        // blank data unless enabled, no start trigger needed
        st_nxt.seg[s] = st_r.ctrl[lcd_seg_pkg::SHOW_BIT] &
                        st_r.shadow[s/2][(s%2)*4 + int'(st_r.com)];
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r      <= '0;
      st_r.ctrl <= lcd_seg_pkg::CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : lcd_seg_ctrl

// ===== src/lcd_seg_pkg.sv
package lcd_seg_pkg;
  // ==========================================================
  // register map (byte addresses on the avalon slave)
  localparam logic [4:0] RAM_W0_OFS = 5'h00;   // ram bytes 0..3, words at 00..0c
  localparam logic [4:0] RAM_W3_OFS = 5'h0c;
  localparam logic [4:0] CTRL_OFS   = 5'h10;
  localparam logic [4:0] STAT_OFS   = 5'h14;
  // ==========================================================
  // control field positions
  localparam int SHOW_BIT  = 4;   // show_ram_enable
  localparam int DUTY_BIT  = 5;   // one third duty when set
  localparam int SRC_BIT   = 3;   // frame_clk_src_sel
  localparam int DIV_HI    = 2;   // frame_clk_div_hi
  localparam int DIV_MID   = 1;   // frame_clk_div_mid
  localparam int DIV_LO    = 0;   // frame_clk_div_lo
  localparam logic [5:0] CTRL_RST = 6'h00;
  // ==========================================================
  // geometry and timing
  localparam int RAM_BYTES   = 16;
  localparam int SEG_COUNT   = 32;
  localparam int COM_COUNT   = 4;
  localparam int PHASE_TICKS = 32;  // 2*4*32 = 256 ticks a frame, 128 Hz at 32.768 kHz
endpackage : lcd_seg_pkg

// ===== verification/lcd_panel_model.sv
`timescale 1ns/1ns
module lcd_panel_model (
  input  wire logic        sys_clk,
  input  wire logic [31:0] segment_line,
  input  wire logic [3:0]  com_line,
  output logic      [31:0] seen [4]
);
  // ====
  // each common keeps the last pattern it saw
  always_ff @(posedge sys_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (com_line[k]) seen[k] <= segment_line;
    end
  end
endmodule : lcd_panel_model

// ===== verification/lcd_seg_monitor.sv
`timescale 1ns/1ns
module lcd_seg_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [31:0] segment_line,
  input wire logic [3:0]  com_line,
  input wire logic        frame_pol
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ====
  // bus and scan steps
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_step; $changed(com_line) && $past(com_line) != 4'h0 && com_line != 4'h0; endsequence
  a_one_wait: assert property (s_req |=> !waitrequest) else $error("late");
  a_idle_free: assert property (!read && !write |-> !waitrequest) else $error("wait");
  a_rd_quiet: assert property (!(read && !waitrequest) |-> readdata == 32'h0) else $error("rd");
  a_com_hot: assert property (com_line != 4'h0 |-> $onehot(com_line)) else $error("com");
  a_stop_blank: assert property (com_line == 4'h0 |-> segment_line == 32'h0) else $error("seg");
  a_com_hold: assert property (s_step |=> $stable(com_line) [*8]) else $error("hold");
  a_com_order: assert property (s_step |->
    com_line == {$past(com_line[2:0]), 1'b0} || com_line == 4'h1) else $error("order");
  a_pol_wrap: assert property (s_step ##0 com_line == 4'h1 |-> $changed(frame_pol)) else $error("pol");
endmodule : lcd_seg_monitor

// ===== verification/test_lcd_seg_ctrl.sv
`timescale 1ns/1ns
module test_lcd_seg_ctrl;
  logic        sys_clk, rst, read, write, watch_clk, sub_clk_mode, waitrequest, frame_pol;
  logic [4:0]  address;
  logic [3:0]  byteenable, com_line;
  logic [31:0] writedata, readdata, segment_line, rd, seen [4];
  logic [31:0] ram [4] = '{32'h0f1e2d3c, 32'h4b5a6978, 32'h8796a5b4, 32'hc3d2e1f0};
  logic [47:0] cd = 48'hfedcba987210; // rows: clock select codes
  int          mismatches, checks_done, n;
  lcd_seg_ctrl uut (.*);
  lcd_panel_model panel (.*);
  // ====
  // clocks: watch clock 10x slower, its edges on sys_clk falling edges
  initial forever #5 sys_clk = ~sys_clk;
  initial forever #50 watch_clk = ~watch_clk;
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t mismatch", $time);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [3:0] b, input logic [31:0] d);
    n = 0;
    address <= a;
    byteenable <= b;
    writedata <= d;
    read <= !w;
    write <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 9);
    if (n > 8) mismatches++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic gap(output int c);
    logic [3:0] p;
    p = com_line;
    c = 0;
    while (com_line === p && c < 9000) begin
      @(posedge sys_clk);
      c++;
    end
  endtask : gap
  function automatic logic [31:0] pat(input int k);
    for (int i = 0; i < 16; i++) begin
      pat[2*i] = ram[i/4][8*(i%4)+k];
      pat[2*i+1] = ram[i/4][8*(i%4)+4+k];
    end
  endfunction : pat
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // main sequence; waits cover the one-frame shadow latency
  initial begin
    {sys_clk, read, write, watch_clk, sub_clk_mode, address, byteenable, writedata} = '0;
    rst = 1'b1;
    mismatches = 0;
    checks_done = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, 5'h10, 4'hf, 0);
    chk(rd, 0);
    for (int i = 0; i < 4; i++) bus(1, 5'(4 * i), 4'hf, ram[i]);
    bus(1, 5'h4, 4'h2, 32'h0000c300);
    ram[1][15:8] = 8'hc3;
    repeat (6000) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) chk(seen[k], 0);
    bus(1, 5'h10, 4'hf, 32'h10);
    repeat (8000) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) chk(seen[k], pat(k));
    $display("map test done");
    for (int i = 0; i < 12; i++) begin
      bus(1, 5'h10, 4'hf, {28'h1, cd[4*i+:4]});
      gap(n);
      gap(n);
      chk(n, i < 4 ? 320 << (i > 2 ? 2 : i) : 64 << (i - 4));
    end
    $display("rate test done");
    sub_clk_mode <= 1'b1;
    bus(1, 5'h10, 4'hf, 32'h18);
    repeat (50) @(posedge sys_clk);
    chk(com_line, 0);
    bus(1, 5'h10, 4'hf, 32'h30);
    while (com_line !== 4'h4) @(posedge sys_clk);
    gap(n);
    chk(com_line, 1);
    bus(0, 5'h18, 4'hf, 0);
    chk(rd, 0);
    end_of_test();
  end
  // watchdog cuts a hang short
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
endmodule : test_lcd_seg_ctrl
bind lcd_seg_ctrl lcd_seg_monitor mon (.*);
